/* File: rtl/bftc_ctrl_if.sv */
// Purpose: Carries control fields from the register bank to the sub-blocks
// Assumes: All members on the single system clock
// Notes: Clear request from the receive packer travels back to the registers
`timescale 1ns/100ps
interface bftc_ctrl_if;
  logic [2:0] rxOffset;
  logic rxOffsetClear;
  logic invB;
  logic cwB;
  logic rfEnA;
  logic rfEnB;

  modport regs (
    output rxOffset,
    output invB,
    output cwB,
    output rfEnA,
    output rfEnB,
    input rxOffsetClear
  );

  modport rx (
    input rxOffset,
    output rxOffsetClear
  );

  modport drv (
    input invB,
    input cwB,
    input rfEnA,
    input rfEnB
  );
endinterface

/* File: rtl/bftc_driver_pair.sv */
// Purpose: Forms the two antenna driver outputs from carrier and modulator
// Assumes: Carrier and modulator already synchronised to the system clock
// Notes: Modulator high lets the carrier through, low blanks it, except on driver B in continuous wave mode
`timescale 1ns/100ps
module bftc_driver_pair (
  input wire logic clk,
  input wire logic rstn,
  bftc_ctrl_if.drv ctrl,
  input wire logic carrier,
  input wire logic modIn,
  output logic antennaDriverA,
  output logic antennaDriverB
);
  logic carrierB;

  // Driver B may run on the inverted carrier
  assign carrierB = ctrl.invB ? ~carrier : carrier;

  // Registered outputs; disabled drivers sit at a constant low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      antennaDriverA <= 1'b0;
      antennaDriverB <= 1'b0;
    end else begin
      antennaDriverA <= ctrl.rfEnA ? (carrier & modIn) : 1'b0;
      if (!ctrl.rfEnB) begin
        antennaDriverB <= 1'b0;
      end else if (ctrl.cwB) begin
        antennaDriverB <= carrierB;
      end else begin
        antennaDriverB <= carrierB & modIn;
      end
    end
  end
endmodule // bftc_driver_pair

/* File: rtl/bftc_pkg.sv */
// Purpose: Shared constants for the bit framing and antenna driver control block
// Assumes: 8-bit register data, 6-bit register address, 20 MHz system clock
// Notes: Every offset, field position, reset value and timing count lives here
package bftc_pkg;

  // Register offsets on the parallel host port
  localparam logic [5:0] ADDR_CRC_UPPER = 6'h0e;
  localparam logic [5:0] ADDR_BIT_FRAMING = 6'h0f;
  localparam logic [5:0] ADDR_DRIVER_CTRL = 6'h11;

  // Reset values
  localparam logic [7:0] RST_BIT_FRAMING = 8'h00;
  localparam logic [7:0] RST_DRIVER_CTRL = 8'h58;
  localparam logic [2:0] RST_FIELD3 = 3'h0;

  // Read answers that carry no state
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [7:0] CRC_UPPER_UNDEFINED = 8'h00;

  // Bit framing field positions
  localparam int RXOFF_LSB = 4;
  localparam int RXOFF_MSB = 6;
  localparam int TXCNT_LSB = 0;
  localparam int TXCNT_MSB = 2;

  // Driver control field positions
  localparam int MODSEL_LSB = 5;
  localparam int MODSEL_MSB = 6;
  localparam int INVB_BIT = 3;
  localparam int CWB_BIT = 2;
  localparam int RFB_BIT = 1;
  localparam int RFA_BIT = 0;

  // Modulator input select codes
  localparam logic [1:0] MOD_LOW = 2'h0;
  localparam logic [1:0] MOD_HIGH = 2'h1;
  localparam logic [1:0] MOD_ENCODER = 2'h2;
  localparam logic [1:0] MOD_EXTERNAL = 2'h3;

  // Byte geometry
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] TOP_BIT_POS = 3'h7;

  // Bit period of the outgoing data stream and its cycle count
  localparam int CLK_PERIOD_NS = 50;
  localparam int BIT_TIME_NS = 9440;
  localparam logic [7:0] BIT_CYCLES = 8'(BIT_TIME_NS / CLK_PERIOD_NS);

endpackage

/* File: rtl/bftc_rx_packer.sv */
// Purpose: Packs received bits into bytes starting at a chosen bit position
// Assumes: Decoder strobes arrive on the system clock, one bit per strobe
// Notes: A part-filled byte is flushed at the end of a reception
`timescale 1ns/100ps
module bftc_rx_packer (
  input wire logic clk,
  input wire logic rstn,
  bftc_ctrl_if.rx ctrl,
  input wire logic rxStart,
  input wire logic rxBitValid,
  input wire logic rxBit,
  input wire logic rxDone,
  output logic [7:0] rxByte,
  output logic rxByteValid
);
  logic [2:0] bitPos_ff;
  logic [7:0] acc_ff;
  logic [7:0] nxt_acc;

  // Current bit dropped into its slot
  always_comb begin
    nxt_acc = acc_ff;
    nxt_acc[bitPos_ff] = rxBit;
  end

  // Position and accumulator; first bit lands at the chosen offset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bitPos_ff <= 3'h0;
      acc_ff <= 8'h00;
    end else if (rxStart) begin
      bitPos_ff <= ctrl.rxOffset;
      acc_ff <= 8'h00;
    end else if (rxBitValid) begin
      bitPos_ff <= bitPos_ff + 3'h1;
      acc_ff <= (bitPos_ff == bftc_pkg::TOP_BIT_POS) ? 8'h00 : nxt_acc;
    end else if (rxDone) begin
      bitPos_ff <= 3'h0;
      acc_ff <= 8'h00;
    end
  end

  // Byte out when full, or partial byte at end of frame
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxByte <= 8'h00;
      rxByteValid <= 1'b0;
    end else begin
      rxByteValid <= 1'b0;
      if (rxBitValid && bitPos_ff == bftc_pkg::TOP_BIT_POS) begin
        rxByte <= nxt_acc;
        rxByteValid <= 1'b1;
      end else if (rxDone && !rxStart && bitPos_ff != 3'h0) begin
        rxByte <= acc_ff;
        rxByteValid <= 1'b1;
      end
    end
  end

  // End of reception asks the registers to zero the offset
  assign ctrl.rxOffsetClear = rxDone;
endmodule // bftc_rx_packer

/* File: rtl/bftc_top.sv */
// Purpose: Bit framing and antenna driver control register bank with datapath
// Assumes: Host pins asynchronous; decoder, FIFO and CRC engine on clk
// Notes: Carrier arrives from the oscillator and is resampled at 20 MHz
//
// Behaviour
// - CRC upper byte readable, valid when complete
// - Eight-bit CRC leaves upper byte undefined
// - Receive offset sets first bit position
// - Offset seven wraps second bit into next byte
// - Receive offset self-clears after reception
// - Final bit count; zero sends whole byte
// - Final bit count self-clears after transmission
// - Modulator input: low, high, encoder, external
// - Invert bit inverts carrier on driver B
// - Continuous wave bit gives unmodulated carrier on driver B
// - Continuous wave clear allows data modulation
// - Driver B enable: modulated carrier or constant
// - Driver A enable: modulated carrier or constant
`timescale 1ns/100ps
module bftc_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hostCsN,
  input wire logic hostRdN,
  input wire logic hostWrN,
  input wire logic [5:0] hostAddr,
  input wire logic [7:0] hostDataIn,
  output logic [7:0] hostDataOut,
  output logic hostDataOe,
  input wire logic [15:0] crcResult,
  input wire logic crcCompleteFlag,
  input wire logic crcEightBit,
  input wire logic rxStart,
  input wire logic rxBitValid,
  input wire logic rxBit,
  input wire logic rxDone,
  output logic [7:0] rxByte,
  output logic rxByteValid,
  input wire logic txStart,
  input wire logic [7:0] txByte,
  input wire logic txByteValid,
  input wire logic txByteLast,
  output logic txByteReady,
  output logic txActive,
  output logic txDone,
  input wire logic carrierIn,
  input wire logic externalModulatorInput,
  output logic antennaDriverA,
  output logic antennaDriverB
);
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT} bftc_tx_e;

  bftc_ctrl_if ctrl ();

  // Host pin synchronisers, two stages each
  logic [2:0] strobeMeta_ff;
  logic [2:0] strobeSync_ff;
  logic [5:0] addrMeta_ff;
  logic [5:0] addrSync_ff;
  logic [7:0] dataMeta_ff;
  logic [7:0] dataSync_ff;
  logic wrPrev_ff;
  logic hostRead;
  logic hostWrite;

  // Carrier and external modulator synchronisers
  logic [1:0] analogMeta_ff;
  logic [1:0] analogSync_ff;

  // Register state
  logic [2:0] receiveBitOffset_ff;
  logic [2:0] transmitFinalBitCount_ff;
  logic [7:0] driverCtrl_ff;
  logic [7:0] readMux;

  // Transmit serializer
  bftc_tx_e txState_ff;
  logic [7:0] txShift_ff;
  logic [3:0] bitsLeft_ff;
  logic txLast_ff;
  logic [7:0] bitDiv_ff;
  logic bitTick;
  logic [3:0] finalBits;
  logic encoderOut;
  logic modulatorIn;

  // Strobes and buses cross from the host pins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strobeMeta_ff <= 3'h7;
      strobeSync_ff <= 3'h7;
      addrMeta_ff <= 6'h00;
      addrSync_ff <= 6'h00;
      dataMeta_ff <= 8'h00;
      dataSync_ff <= 8'h00;
    end else begin
      strobeMeta_ff <= {hostCsN, hostRdN, hostWrN};
      strobeSync_ff <= strobeMeta_ff;
      addrMeta_ff <= hostAddr;
      addrSync_ff <= addrMeta_ff;
      dataMeta_ff <= hostDataIn;
      dataSync_ff <= dataMeta_ff;
    end
  end

  // Carrier and external modulator cross from outside
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      analogMeta_ff <= 2'h0;
      analogSync_ff <= 2'h0;
    end else begin
      analogMeta_ff <= {carrierIn, externalModulatorInput};
      analogSync_ff <= analogMeta_ff;
    end
  end

  // Write taken on the rising edge of the write strobe, data then stable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPrev_ff <= 1'b1;
    end else begin
      wrPrev_ff <= strobeSync_ff[0];
    end
  end

  assign hostRead = !strobeSync_ff[2] && !strobeSync_ff[1];
  assign hostWrite = !strobeSync_ff[2] && strobeSync_ff[0] && !wrPrev_ff;

  // Receive offset; software write wins over the end-of-frame clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      receiveBitOffset_ff <= bftc_pkg::RST_BIT_FRAMING[bftc_pkg::RXOFF_MSB:bftc_pkg::RXOFF_LSB];
    end else if (hostWrite && addrSync_ff == bftc_pkg::ADDR_BIT_FRAMING) begin
      receiveBitOffset_ff <= dataSync_ff[bftc_pkg::RXOFF_MSB:bftc_pkg::RXOFF_LSB];
    end else if (ctrl.rxOffsetClear) begin
      receiveBitOffset_ff <= bftc_pkg::RST_FIELD3;
    end
  end

  // Final bit count; cleared when the frame leaves
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      transmitFinalBitCount_ff <= bftc_pkg::RST_BIT_FRAMING[bftc_pkg::TXCNT_MSB:bftc_pkg::TXCNT_LSB];
    end else if (hostWrite && addrSync_ff == bftc_pkg::ADDR_BIT_FRAMING) begin
      transmitFinalBitCount_ff <= dataSync_ff[bftc_pkg::TXCNT_MSB:bftc_pkg::TXCNT_LSB];
    end else if (txDone) begin
      transmitFinalBitCount_ff <= bftc_pkg::RST_FIELD3;
    end
  end

  // Driver control; fixed bits stored as written, host keeps them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      driverCtrl_ff <= bftc_pkg::RST_DRIVER_CTRL;
    end else if (hostWrite && addrSync_ff == bftc_pkg::ADDR_DRIVER_CTRL) begin
      driverCtrl_ff <= dataSync_ff;
    end
  end

  assign ctrl.rxOffset = receiveBitOffset_ff;
  assign ctrl.invB = driverCtrl_ff[bftc_pkg::INVB_BIT];
  assign ctrl.cwB = driverCtrl_ff[bftc_pkg::CWB_BIT];
  assign ctrl.rfEnA = driverCtrl_ff[bftc_pkg::RFA_BIT];
  assign ctrl.rfEnB = driverCtrl_ff[bftc_pkg::RFB_BIT];

  // Read decode; reserved framing bits read as zero
  always_comb begin
    case (addrSync_ff)
      bftc_pkg::ADDR_CRC_UPPER: begin
        // Host must check the complete flag itself; no gating on it here
        readMux = crcEightBit ? bftc_pkg::CRC_UPPER_UNDEFINED : crcResult[15:8];
      end
      bftc_pkg::ADDR_BIT_FRAMING: begin
        readMux = {1'b0, receiveBitOffset_ff, 1'b0, transmitFinalBitCount_ff};
      end
      bftc_pkg::ADDR_DRIVER_CTRL: begin
        readMux = driverCtrl_ff;
      end
      default: begin
        readMux = bftc_pkg::UNMAPPED_READ;
      end
    endcase
  end

  // Data bus driven one cycle after the synchronised read strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hostDataOut <= 8'h00;
      hostDataOe <= 1'b0;
    end else begin
      hostDataOe <= hostRead;
      if (hostRead) begin
        hostDataOut <= readMux;
      end
    end
  end

  // Bit period divider, restarted with every loaded byte
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bitDiv_ff <= 8'h00;
    end else if (txState_ff != TX_SHIFT || bitTick) begin
      bitDiv_ff <= 8'h00;
    end else begin
      bitDiv_ff <= bitDiv_ff + 8'h01;
    end
  end

  assign bitTick = (txState_ff == TX_SHIFT) && (bitDiv_ff == bftc_pkg::BIT_CYCLES - 8'h01);

  // Zero count means the whole final byte goes out
  assign finalBits = (transmitFinalBitCount_ff == 3'h0) ? bftc_pkg::BITS_PER_BYTE
                                                        : {1'b0, transmitFinalBitCount_ff};

  // Serializer sequence, LSB first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txState_ff <= TX_IDLE;
      txShift_ff <= 8'h00;
      bitsLeft_ff <= 4'h0;
      txLast_ff <= 1'b0;
      txDone <= 1'b0;
    end else begin
      txDone <= 1'b0;
      case (txState_ff)
        TX_IDLE: begin
          if (txStart) begin
            txState_ff <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (txByteValid) begin
            txShift_ff <= txByte;
            bitsLeft_ff <= txByteLast ? finalBits : bftc_pkg::BITS_PER_BYTE;
            txLast_ff <= txByteLast;
            txState_ff <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (bitTick) begin
            txShift_ff <= {1'b0, txShift_ff[7:1]};
            bitsLeft_ff <= bitsLeft_ff - 4'h1;
            if (bitsLeft_ff == 4'h1) begin
              txState_ff <= txLast_ff ? TX_IDLE : TX_WAIT;
              txDone <= txLast_ff;
            end
          end
        end
        default: begin
          txState_ff <= TX_IDLE;
        end
      endcase
    end
  end

  assign txByteReady = (txState_ff == TX_WAIT);
  assign txActive = (txState_ff != TX_IDLE);

  // Encoder idles high so an unused stream leaves the carrier on
  assign encoderOut = (txState_ff == TX_SHIFT) ? txShift_ff[0] : 1'b1;

  // Modulator source select
  always_comb begin
    case (driverCtrl_ff[bftc_pkg::MODSEL_MSB:bftc_pkg::MODSEL_LSB])
      bftc_pkg::MOD_LOW: begin
        modulatorIn = 1'b0;
      end
      bftc_pkg::MOD_HIGH: begin
        modulatorIn = 1'b1;
      end
      bftc_pkg::MOD_ENCODER: begin
        modulatorIn = encoderOut;
      end
      bftc_pkg::MOD_EXTERNAL: begin
        modulatorIn = analogSync_ff[0];
      end
      default: begin
        modulatorIn = 1'b0;
      end
    endcase
  end

  // Receive bit placement
  bftc_rx_packer rxPacker (
    .clk(clk),
    .rstn(rstn),
    .ctrl(ctrl.rx),
    .rxStart(rxStart),
    .rxBitValid(rxBitValid),
    .rxBit(rxBit),
    .rxDone(rxDone),
    .rxByte(rxByte),
    .rxByteValid(rxByteValid)
  );

  // Antenna driver pair
  bftc_driver_pair drivers (
    .clk(clk),
    .rstn(rstn),
    .ctrl(ctrl.drv),
    .carrier(analogSync_ff[1]),
    .modIn(modulatorIn),
    .antennaDriverA(antennaDriverA),
    .antennaDriverB(antennaDriverB)
  );
endmodule // bftc_top

/* File: test/bftc_host_model.sv */
// Purpose: Host processor model on the parallel register pins
// Assumes: Strobes held six cycles, well over the four-cycle minimum
// Notes: Released data lines are inverted so stale values cannot pass
`timescale 1ns/100ps
module bftc_host_model (
  input wire logic clk,
  output logic hostCsN,
  output logic hostRdN,
  output logic hostWrN,
  output logic [5:0] hostAddr,
  output logic [7:0] hostDataIn,
  input wire logic [7:0] hostDataOut,
  input wire logic hostDataOe
);
  initial begin
    hostCsN = 1'b1;
    hostRdN = 1'b1;
    hostWrN = 1'b1;
    hostAddr = 6'h00;
    hostDataIn = 8'h00;
  end
  // Chip select outlasts the write strobe so the synced edge sees it low
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    hostCsN <= 1'b0;
    hostAddr <= a;
    hostDataIn <= (a == bftc_pkg::ADDR_DRIVER_CTRL) ? ((d & 8'h7f) | 8'h10) : d;
    hostWrN <= 1'b0;
    repeat (6) @(posedge clk);
    hostWrN <= 1'b1;
    repeat (6) @(posedge clk);
    hostCsN <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  // Data is taken only while the device drives the bus
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    hostCsN <= 1'b0;
    hostAddr <= a;
    hostDataIn <= ~hostDataIn;
    hostRdN <= 1'b0;
    repeat (6) @(posedge clk);
    d = (hostDataOe === 1'b1) ? hostDataOut : 8'hxx;
    hostRdN <= 1'b1;
    hostCsN <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule // bftc_host_model

/* File: test/bftc_top_bench.sv */
// Purpose: Self-checking bench for registers, receive packing, transmit and drivers
// Assumes: Host model drives register pins, bench drives all same-clock inputs
// Notes: Received bytes are checked through an expectation queue
`timescale 1ns/100ps
module bftc_top_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hostCsN, hostRdN, hostWrN, hostDataOe, rxByteValid, txByteReady, txActive, txDone;
  logic antennaDriverA, antennaDriverB;
  logic [5:0] hostAddr;
  logic [7:0] hostDataIn, hostDataOut, rxByte, rv, data;
  logic [15:0] crcResult = 16'h0000;
  logic crcCompleteFlag = 1'b0, crcEightBit = 1'b0, rxStart = 1'b0, rxBitValid = 1'b0, rxBit = 1'b0;
  logic rxDone = 1'b0, txStart = 1'b0, txByteValid = 1'b0, txByteLast = 1'b0;
  logic carrierIn = 1'b0, externalModulatorInput = 1'b0;
  logic [7:0] txByte = 8'h00;
  logic [7:0] rxQ[$];
  logic [2:0] offs[3] = '{3'h0, 3'h1, 3'h7};
  // Last row runs driver B uninverted so a stuck inverter shows up
  logic [7:0] drvVal[8] = '{8'h1e, 8'h1a, 8'h3a, 8'h39, 8'h38, 8'h79, 8'h79, 8'h16};
  logic [3:0] drvIo[8] = '{4'h1, 4'h0, 4'h1, 4'ha, 4'h8, 4'he, 4'h8, 4'h9};
  int fail_count = 0;
  int comparisons = 0;
  int seed = 15;
  int n;
  always #25 clk = ~clk;
  bftc_host_model bftc_host_model_i (.clk(clk), .hostCsN(hostCsN), .hostRdN(hostRdN), .hostWrN(hostWrN),
    .hostAddr(hostAddr), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe));
  bftc_top bftc_top_i (.clk(clk), .rstn(rstn), .hostCsN(hostCsN), .hostRdN(hostRdN), .hostWrN(hostWrN),
    .hostAddr(hostAddr), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
    .crcResult(crcResult), .crcCompleteFlag(crcCompleteFlag), .crcEightBit(crcEightBit), .rxStart(rxStart),
    .rxBitValid(rxBitValid), .rxBit(rxBit), .rxDone(rxDone), .rxByte(rxByte), .rxByteValid(rxByteValid),
    .txStart(txStart), .txByte(txByte), .txByteValid(txByteValid), .txByteLast(txByteLast),
    .txByteReady(txByteReady), .txActive(txActive), .txDone(txDone), .carrierIn(carrierIn),
    .externalModulatorInput(externalModulatorInput), .antennaDriverA(antennaDriverA),
    .antennaDriverB(antennaDriverB));
  task automatic checkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic checkBit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Oldest expectation is matched against each received byte
  always @(posedge clk) begin
    if (rstn && rxByteValid === 1'b1) begin
      checkByte("rxByte", rxQ.size() > 0 ? rxQ.pop_front() : 8'hxx, rxByte);
    end
  end
  // Generous limit: the longest phase is one short frame
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    bftc_host_model_i.rd(bftc_pkg::ADDR_BIT_FRAMING, rv);
    checkByte("framing reset", bftc_pkg::RST_BIT_FRAMING, rv);
    bftc_host_model_i.rd(bftc_pkg::ADDR_DRIVER_CTRL, rv);
    checkByte("driver reset", 8'h58, rv);
    crcResult <= 16'($random(seed));
    crcCompleteFlag <= 1'b1;
    bftc_host_model_i.rd(bftc_pkg::ADDR_CRC_UPPER, rv);
    checkByte("crc upper", crcResult[15:8], rv);
    crcEightBit <= 1'b1;
    bftc_host_model_i.rd(bftc_pkg::ADDR_CRC_UPPER, rv);
    checkByte("crc upper 8-bit", bftc_pkg::CRC_UPPER_UNDEFINED, rv);
    bftc_host_model_i.rd(6'h20, rv);
    checkByte("unmapped", bftc_pkg::UNMAPPED_READ, rv);
    bftc_host_model_i.wr(bftc_pkg::ADDR_BIT_FRAMING, 8'hff);
    bftc_host_model_i.rd(bftc_pkg::ADDR_BIT_FRAMING, rv);
    checkByte("framing reserved", 8'h77, rv);
    // Offsets 0, 1 and 7: at 1 and 7 the bits past the top spill into a second byte
    foreach (offs[i]) begin
      bftc_host_model_i.wr(bftc_pkg::ADDR_BIT_FRAMING, {1'b0, offs[i], 4'h0});
      data = 8'($random(seed));
      rxQ.push_back(data << offs[i]);
      if (offs[i] != 3'h0) rxQ.push_back(data >> (4'h8 - offs[i]));
      rxStart <= 1'b1;
      @(posedge clk);
      rxStart <= 1'b0;
      for (int k = 0; k < 8; k++) begin
        rxBitValid <= 1'b1;
        rxBit <= data[k];
        @(posedge clk);
      end
      rxBitValid <= 1'b0;
      rxDone <= 1'b1;
      @(posedge clk);
      rxDone <= 1'b0;
      repeat (3) @(posedge clk);
      bftc_host_model_i.rd(bftc_pkg::ADDR_BIT_FRAMING, rv);
      checkByte("offset cleared", 8'h00, rv);
    end
    checkBit("rx queue empty", 1'b1, rxQ.size() == 0);
    // Three-bit last byte through the encoder onto driver A
    carrierIn <= 1'b1;
    bftc_host_model_i.wr(bftc_pkg::ADDR_BIT_FRAMING, 8'h03);
    bftc_host_model_i.wr(bftc_pkg::ADDR_DRIVER_CTRL, 8'h51);
    data = 8'($random(seed));
    txStart <= 1'b1;
    @(posedge clk);
    txStart <= 1'b0;
    txByte <= data;
    txByteValid <= 1'b1;
    txByteLast <= 1'b1;
    // Offer stands until the edge at which ready is seen high
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (txByteReady !== 1'b1 && n < 20);
    txByteValid <= 1'b0;
    for (n = 1; n < 1000 && txDone !== 1'b1; n++) begin
      @(posedge clk);
      if (n % bftc_pkg::BIT_CYCLES == 94 && n < 3 * bftc_pkg::BIT_CYCLES)
        checkBit("tx bit", data[n / bftc_pkg::BIT_CYCLES], antennaDriverA);
    end
    checkBit("tx length", 1'b1, n >= 3 * bftc_pkg::BIT_CYCLES && n <= 3 * bftc_pkg::BIT_CYCLES + 5);
    bftc_host_model_i.rd(bftc_pkg::ADDR_BIT_FRAMING, rv);
    checkByte("count cleared", 8'h00, rv);
    bftc_host_model_i.rd(bftc_pkg::ADDR_DRIVER_CTRL, rv);
    checkByte("driver readback", 8'h51, rv);
    // Each row: control value, carrier, external pin, expected A, expected B
    foreach (drvVal[i]) begin
      bftc_host_model_i.wr(bftc_pkg::ADDR_DRIVER_CTRL, drvVal[i]);
      carrierIn <= drvIo[i][3];
      externalModulatorInput <= drvIo[i][2];
      repeat (8) @(posedge clk);
      checkBit("driver A", drvIo[i][1], antennaDriverA);
      checkBit("driver B", drvIo[i][0], antennaDriverB);
    end
    print_verdict();
  end
endmodule // bftc_top_bench
bind bftc_top bftc_top_props bftc_top_props_i (.clk(clk), .rstn(rstn), .hostCsN(hostCsN), .hostRdN(hostRdN),
  .hostWrN(hostWrN), .hostAddr(hostAddr), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
  .hostDataOe(hostDataOe), .rxBitValid(rxBitValid), .rxDone(rxDone), .rxByteValid(rxByteValid),
  .txStart(txStart), .txByteReady(txByteReady), .txActive(txActive), .txDone(txDone), .carrierIn(carrierIn),
  .antennaDriverA(antennaDriverA), .antennaDriverB(antennaDriverB));

/* File: test/bftc_top_props.sv */
// Purpose: Port-level timing checks for the framing and driver block
// Assumes: One clock, rstn asynchronous active low
// Notes: Register contents are not visible, so checks tie outputs to pins
`timescale 1ns/100ps
module bftc_top_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hostCsN,
  input wire logic hostRdN,
  input wire logic hostWrN,
  input wire logic [5:0] hostAddr,
  input wire logic [7:0] hostDataIn,
  input wire logic [7:0] hostDataOut,
  input wire logic hostDataOe,
  input wire logic rxBitValid,
  input wire logic rxDone,
  input wire logic rxByteValid,
  input wire logic txStart,
  input wire logic txByteReady,
  input wire logic txActive,
  input wire logic txDone,
  input wire logic carrierIn,
  input wire logic antennaDriverA,
  input wire logic antennaDriverB
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Bus is driven only after a synced read strobe
  a_oe_needs_read: assert property ($rose(hostDataOe) |-> $past(!hostCsN && !hostRdN, 3))
    else $error("data enable rose without read");
  a_oe_release: assert property ($rose(hostRdN) |-> ##[1:5] !hostDataOe)
    else $error("data enable held after read");
  a_tx_enters: assert property (txStart && !txActive |=> txActive)
    else $error("transmit start not taken");
  a_ready_inside: assert property (txByteReady |-> txActive)
    else $error("byte ready outside frame");
  a_done_single: assert property (txDone |=> !txDone)
    else $error("transmit done longer than one cycle");
  // Frame must close within two cycles of its done pulse
  a_done_closes: assert property (txDone |-> ##[0:2] !txActive)
    else $error("frame active after done");
  a_rxbyte_cause: assert property (rxByteValid |-> $past(rxBitValid || rxDone))
    else $error("received byte without bit or end");
  a_rxbyte_single: assert property (rxByteValid |=> !rxByteValid)
    else $error("received byte strobe too long");
  // Sync latency is three cycles; the window also accepts the carrier two and four cycles back
  a_drva_carrier: assert property (antennaDriverA |-> $past(carrierIn, 2) || $past(carrierIn, 3) || $past(carrierIn, 4))
    else $error("driver A high without carrier");
  c_rx_byte: cover property (rxByteValid);
  c_tx_done: cover property (txDone);
  c_drv_b: cover property (antennaDriverB);
  c_read: cover property (hostDataOe);
endmodule // bftc_top_props
